// *** verilog/sdcr_pkg.sv ***
// Constants for the socket DMA, diagnostic and capability configuration bytes.
// Assumes byte addressing of configuration space with 32-bit data words.
package sdcr_pkg;
   // Byte addresses of the words this block answers
   localparam logic [7:0] SDCR_OFS_IDENT = 8'h00;
   localparam logic [7:0] SDCR_OFS_DIAG_DW = 8'h90;
   localparam logic [7:0] SDCR_OFS_DMA_REQ = 8'h94;
   localparam logic [7:0] SDCR_OFS_DMA_BASE = 8'h98;
   localparam logic [7:0] SDCR_OFS_CAP_DW = 8'hA0;
   // Byte lanes inside the shared words
   localparam int SDCR_DIAG_LANE = 3;
   localparam int SDCR_CAP_ID_LANE = 0;
   localparam int SDCR_NEXT_LANE = 1;
   // Diagnostic byte layout and reset value
   localparam logic [7:0] SDCR_DIAG_RESET = 8'h61;
   localparam int SDCR_DIAG_ID_MASK = 7;
   localparam int SDCR_DIAG_CSC_ROUTE = 5;
   localparam int SDCR_DIAG_DELAYED_TXN_DISABLE = 4;
   localparam int SDCR_DIAG_RETRY_LATENCY_EXTEND = 3;
   localparam int SDCR_DIAG_CARD_TIM = 2;
   localparam int SDCR_DIAG_HOST_TIM = 1;
   localparam int SDCR_DIAG_ASYNC = 0;
   // Socket DMA words: reset values and writable bits
   localparam logic [31:0] SDCR_DMA_REQ_RESET = 32'h0000_0000;
   localparam logic [31:0] SDCR_DMA_REQ_WMASK = 32'h0000_0003;
   localparam logic [31:0] SDCR_DMA_BASE_RESET = 32'h0000_0000;
   localparam logic [31:0] SDCR_DMA_BASE_WMASK = 32'h0000_FFF7;
   localparam int SDCR_BASE_LSB = 4;
   localparam int SDCR_BASE_MSB = 15;
   localparam int SDCR_WIDTH_LSB = 1;
   localparam int SDCR_WIDTH_MSB = 2;
   localparam int SDCR_DECODE_EN = 0;
   localparam logic [1:0] SDCR_WIDTH_8 = 2'h0;
   localparam logic [1:0] SDCR_WIDTH_16 = 2'h1;
   localparam logic [15:0] SDCR_IO_UPPER_ZERO = 16'h0000;
   // Capability item constants
   localparam logic [7:0] SDCR_CAP_ID_VAL = 8'h01;
   localparam logic [7:0] SDCR_NEXT_PTR_VAL = 8'h00;
   localparam logic [31:0] SDCR_ALL_ONES = 32'hFFFF_FFFF;
   localparam logic [31:0] SDCR_ZERO_WORD = 32'h0000_0000;
   // Retry latency limits and discard timeouts, as counts
   localparam logic [6:0] SDCR_RETRY_LAT_BASE = 7'h10;
   localparam logic [6:0] SDCR_RETRY_LAT_EXT = 7'h40;
   localparam logic [15:0] SDCR_DISCARD_SHORT = 16'h0400;
   localparam logic [15:0] SDCR_DISCARD_LONG = 16'h8000;
endpackage

// *** verilog/sdcr_regs.sv ***
// Diagnostic, socket DMA and capability configuration bytes of the socket bridge.
// Assumes a one-cycle configuration access strobe from host bus logic on mclk.
`timescale 1ns/100ps
module sdcr_regs
   import sdcr_pkg::*;
#(
   parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
   parameter logic [15:0] DEVICE_ID = 16'h5678  // Arbitrary value
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic legacy_csc_enable,
   input wire logic [3:0] legacy_csc_irq_sel,
   input wire logic [31:0] io_addr,
   input wire logic io_valid,
   output logic identity_mask_select,
   output logic status_change_route_select,
   output logic delayed_txn_disable,
   output logic retry_latency_extend,
   output logic [6:0] retry_latency_limit,
   output logic [15:0] card_side_discard_timeout,
   output logic [15:0] host_side_discard_timeout,
   output logic async_interrupt_enable,
   output logic csc_host_route_enable,
   output logic [1:0] dma_request_pin_select,
   output logic [11:0] dma_window_base,
   output logic dma_transfer_wide,
   output logic dma_window_decode_enable,
   output logic dma_window_hit
);

   // Word match on the dword part of the byte address
   function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] ofs);
      word_hit = (addr[7:2] == ofs[7:2]);
   endfunction

   // Byte-enable merge limited to the writable bits
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] be,
                                         input logic [31:0] wmask);
      logic [31:0] lanes;
      lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      merge = (old_v & ~(lanes & wmask)) | (new_v & lanes & wmask);
   endfunction

   logic [7:0] diag_r;
   logic [7:0] diag_nxt;
   logic [31:0] dma_req_r;
   logic [31:0] dma_req_nxt;
   logic [31:0] dma_base_r;
   logic [31:0] dma_base_nxt;
   logic [6:0] retry_limit_r;
   logic [6:0] retry_limit_nxt;
   logic [15:0] card_tim_r;
   logic [15:0] card_tim_nxt;
   logic [15:0] host_tim_r;
   logic [15:0] host_tim_nxt;
   logic wide_r;
   logic wide_nxt;

   // Register writes and settings derived from the new values
   always_comb begin
      diag_nxt = diag_r;
      dma_req_nxt = dma_req_r;
      dma_base_nxt = dma_base_r;
      if (cfg_wr && word_hit(cfg_addr, SDCR_OFS_DIAG_DW) && cfg_be[SDCR_DIAG_LANE]) begin
         diag_nxt = cfg_wdata[SDCR_DIAG_LANE*8 +: 8];
      end
      if (cfg_wr && word_hit(cfg_addr, SDCR_OFS_DMA_REQ)) begin
         dma_req_nxt = merge(dma_req_r, cfg_wdata, cfg_be, SDCR_DMA_REQ_WMASK);
      end
      if (cfg_wr && word_hit(cfg_addr, SDCR_OFS_DMA_BASE)) begin
         // Mask keeps bit 3 and the top half at zero
         dma_base_nxt = merge(dma_base_r, cfg_wdata, cfg_be, SDCR_DMA_BASE_WMASK);
      end
      retry_limit_nxt = diag_nxt[SDCR_DIAG_RETRY_LATENCY_EXTEND] ?
                        SDCR_RETRY_LAT_EXT : SDCR_RETRY_LAT_BASE;
      card_tim_nxt = diag_nxt[SDCR_DIAG_CARD_TIM] ?
                     SDCR_DISCARD_SHORT : SDCR_DISCARD_LONG;
      host_tim_nxt = diag_nxt[SDCR_DIAG_HOST_TIM] ?
                     SDCR_DISCARD_SHORT : SDCR_DISCARD_LONG;
      // Reserved width codes fall back to 8 bits; never wider than 16
      wide_nxt = (dma_base_nxt[SDCR_WIDTH_MSB:SDCR_WIDTH_LSB] == SDCR_WIDTH_16);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         diag_r <= SDCR_DIAG_RESET;
         dma_req_r <= SDCR_DMA_REQ_RESET;
         dma_base_r <= SDCR_DMA_BASE_RESET;
         retry_limit_r <= SDCR_RETRY_LAT_BASE;
         card_tim_r <= SDCR_DISCARD_LONG;
         host_tim_r <= SDCR_DISCARD_LONG;
         wide_r <= 1'b0;
      end else begin
         diag_r <= diag_nxt;
         dma_req_r <= dma_req_nxt;
         dma_base_r <= dma_base_nxt;
         retry_limit_r <= retry_limit_nxt;
         card_tim_r <= card_tim_nxt;
         host_tim_r <= host_tim_nxt;
         wide_r <= wide_nxt;
      end
   end

   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;

   // Read mux; unmapped words and foreign bytes answer zero
   always_comb begin
      rdata_nxt = SDCR_ZERO_WORD;
      rvalid_nxt = cfg_rd;
      if (cfg_rd) begin
         if (word_hit(cfg_addr, SDCR_OFS_IDENT)) begin
            // Stored identifiers stay intact; only the answer is masked
            rdata_nxt = diag_r[SDCR_DIAG_ID_MASK] ? SDCR_ALL_ONES
                        : {DEVICE_ID, VENDOR_ID};
         end else if (word_hit(cfg_addr, SDCR_OFS_DIAG_DW)) begin
            rdata_nxt[SDCR_DIAG_LANE*8 +: 8] = diag_r;
         end else if (word_hit(cfg_addr, SDCR_OFS_DMA_REQ)) begin
            rdata_nxt = dma_req_r;
         end else if (word_hit(cfg_addr, SDCR_OFS_DMA_BASE)) begin
            rdata_nxt = dma_base_r;
         end else if (word_hit(cfg_addr, SDCR_OFS_CAP_DW)) begin
            rdata_nxt[SDCR_CAP_ID_LANE*8 +: 8] = SDCR_CAP_ID_VAL;
            rdata_nxt[SDCR_NEXT_LANE*8 +: 8] = SDCR_NEXT_PTR_VAL;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_r <= SDCR_ZERO_WORD;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   logic csc_route_r;
   logic csc_route_nxt;
   logic hit_r;
   logic hit_nxt;

   // Status change routing and DMA window decode
   always_comb begin
      if (diag_r[SDCR_DIAG_CSC_ROUTE]) begin
         csc_route_nxt = (legacy_csc_irq_sel == 4'h0);
      end else begin
         csc_route_nxt = legacy_csc_enable;
      end
      // Low four address bits are part of the 16-byte window
      hit_nxt = io_valid && dma_base_r[SDCR_DECODE_EN]
                && (io_addr[31:16] == SDCR_IO_UPPER_ZERO)
                && (io_addr[15:4] == dma_base_r[SDCR_BASE_MSB:SDCR_BASE_LSB]);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         csc_route_r <= 1'b0;
         hit_r <= 1'b0;
      end else begin
         csc_route_r <= csc_route_nxt;
         hit_r <= hit_nxt;
      end
   end

   // Outputs straight from the register flops
   assign cfg_rdata = rdata_r;
   assign cfg_rvalid = rvalid_r;
   assign identity_mask_select = diag_r[SDCR_DIAG_ID_MASK];
   assign status_change_route_select = diag_r[SDCR_DIAG_CSC_ROUTE];
   assign delayed_txn_disable = diag_r[SDCR_DIAG_DELAYED_TXN_DISABLE];
   assign retry_latency_extend = diag_r[SDCR_DIAG_RETRY_LATENCY_EXTEND];
   assign retry_latency_limit = retry_limit_r;
   assign card_side_discard_timeout = card_tim_r;
   assign host_side_discard_timeout = host_tim_r;
   assign async_interrupt_enable = diag_r[SDCR_DIAG_ASYNC];
   assign csc_host_route_enable = csc_route_r;
   assign dma_request_pin_select = dma_req_r[1:0];
   assign dma_window_base = dma_base_r[SDCR_BASE_MSB:SDCR_BASE_LSB];
   assign dma_transfer_wide = wide_r;
   assign dma_window_decode_enable = dma_base_r[SDCR_DECODE_EN];
   assign dma_window_hit = hit_r;

endmodule

// *** verification/sdcr_host_model.sv ***
// Host bus model: one configuration write or read at a time.
// Assumes mclk from the bench and a read answer one cycle after the strobe.
`timescale 1ns/100ps
module sdcr_host_model (
   input wire logic mclk,
   output logic [7:0] cfg_addr = 8'h00,
   output logic cfg_wr = 1'b0,
   output logic cfg_rd = 1'b0,
   output logic [3:0] cfg_be = 4'h0,
   output logic [31:0] cfg_wdata = 32'h0000_0000,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid
);
   // One taking edge, then one more so the update shows
   task wr(input logic [7:0] ad, input logic [3:0] b, input logic [31:0] v);
      @(posedge mclk) #1;
      {cfg_addr, cfg_be, cfg_wdata, cfg_wr} = {ad, b, v, 1'b1};
      @(posedge mclk) #1;
      cfg_wr = 1'b0;
      cfg_wdata = ~v; // Released data never shows the old value
      @(posedge mclk) #1;
   endtask
   // A missing answer comes back unknown
   task rd(input logic [7:0] ad, output logic [31:0] v);
      @(posedge mclk) #1;
      {cfg_addr, cfg_rd} = {ad, 1'b1};
      @(posedge mclk) #1;
      cfg_rd = 1'b0;
      v = (cfg_rvalid === 1'b1) ? cfg_rdata : 32'hXXXX_XXXX;
   endtask
endmodule

// *** verification/sdcr_regs_sva.sv ***
// Port checks of the configuration bytes block.
// Assumes one mclk domain with synchronous active-high rst.
`timescale 1ns/100ps
module sdcr_regs_sva (
   input wire logic mclk, rst, cfg_rd, cfg_rvalid, identity_mask_select,
   input wire logic retry_latency_extend, dma_window_decode_enable, dma_window_hit,
   input wire logic [7:0] cfg_addr,
   input wire logic [31:0] cfg_rdata,
   input wire logic [6:0] retry_latency_limit
);
   // Single domain, so clock and reset are given once
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   rd_answer_a: assert property (cfg_rd |=> cfg_rvalid) else $error("read lost");
   rd_quiet_a: assert property (!cfg_rd |=> !cfg_rvalid) else $error("stray answer");
   id_mask_a: assert property (cfg_rd && cfg_addr == 8'h00 && identity_mask_select |=>
      cfg_rdata == 32'hFFFF_FFFF) else $error("identity not masked");
   retry_limit_a: assert property (retry_latency_limit ==
      (retry_latency_extend ? 7'h40 : 7'h10)) else $error("bad retry limit");
   dma0_zero_a: assert property (cfg_rd && cfg_addr == 8'h94 |=>
      cfg_rdata[31:2] == 30'h0) else $error("dma word 0 reserved bits set");
   dma1_zero_a: assert property (cfg_rd && cfg_addr == 8'h98 |=>
      cfg_rdata[31:16] == 16'h0 && !cfg_rdata[3]) else $error("dma word 1 reserved set");
   cap_word_a: assert property (cfg_rd && cfg_addr == 8'hA0 |=>
      cfg_rdata == 32'h0000_0001) else $error("bad capability word");
   no_decode_a: assert property (!dma_window_decode_enable |=> !dma_window_hit)
      else $error("hit with decode off");
endmodule
bind sdcr_regs sdcr_regs_sva u_sva (.*);

// *** verification/tb.sv ***
// Self-checking bench for the configuration bytes block.
// Assumes the host model runs config cycles; the bench drives the other inputs.
`timescale 1ns/100ps
module tb;
   logic mclk = 1'b0, rst = 1'b1, legacy_csc_enable = 1'b0, io_valid = 1'b0;
   logic cfg_wr, cfg_rd, cfg_rvalid, identity_mask_select, status_change_route_select;
   logic delayed_txn_disable, retry_latency_extend, async_interrupt_enable;
   logic csc_host_route_enable, dma_transfer_wide, dma_window_decode_enable, dma_window_hit;
   logic [3:0] legacy_csc_irq_sel = 4'h0, cfg_be;
   logic [31:0] io_addr = 32'h0000_0000, cfg_wdata, cfg_rdata, d;
   logic [15:0] card_side_discard_timeout, host_side_discard_timeout;
   logic [11:0] dma_window_base;
   logic [6:0] retry_latency_limit;
   logic [1:0] dma_request_pin_select;
   logic [7:0] cfg_addr, ra [6] = '{8'h90, 8'h94, 8'h98, 8'hA0, 8'h00, 8'h50};
   logic [31:0] re [6] = '{32'h6100_0000, 32'h0, 32'h0, 32'h1, 32'h5678_1234, 32'h0};
   int n_mismatch = 0, samples_checked = 0;
   // Diagnostic outputs gathered for compact compares
   wire [4:0] flags = {identity_mask_select, status_change_route_select,
      delayed_txn_disable, retry_latency_extend, async_interrupt_enable};
   wire [31:0] tims = {card_side_discard_timeout, host_side_discard_timeout};
   sdcr_regs u_dut (.*);
   sdcr_host_model u_host (.*);
   // Clock at 100 ns period
   initial forever #50 mclk = ~mclk;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) n_mismatch++;
      if (s !== e) $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
   endtask
   task close_out;
      $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Defaults, a write to read-only bytes, an unmapped read
   task t_reset;
      chk(flags, 32'h09);
      chk(tims, 32'h8000_8000);
      u_host.wr(8'hA0, 4'hF, 32'hFFFF_FFFF);
      for (int i = 0; i < 6; i++) begin
         u_host.rd(ra[i], d);
         chk(d, re[i]);
      end
   endtask
   // Every diagnostic bit turned round, identity masked and unmasked
   task t_diag;
      u_host.wr(8'h90, 4'h8, 32'h9E00_0000);
      chk(flags, 32'h16);
      chk(tims, 32'h0400_0400);
      u_host.rd(8'h00, d);
      chk(d, 32'hFFFF_FFFF);
      u_host.wr(8'h90, 4'h8, 32'h6100_0000);
      u_host.rd(8'h00, d);
      chk(d, 32'h5678_1234);
   endtask
   // Routing under both selections; the ignored input is set against the result
   task t_route;
      chk(csc_host_route_enable, 32'h1);
      legacy_csc_irq_sel = 4'h5;
      legacy_csc_enable = 1'b1;
      @(posedge mclk) #1;
      chk(csc_host_route_enable, 32'h0);
      u_host.wr(8'h90, 4'h8, 32'h4100_0000);
      chk(csc_host_route_enable, 32'h1);
      legacy_csc_enable = 1'b0;
      @(posedge mclk) #1;
      chk(csc_host_route_enable, 32'h0);
   endtask
   // All pin and width codes, base word read-back mask, window decode and lane gating
   task t_dma;
      for (int i = 0; i < 4; i++) begin
         u_host.wr(8'h94, 4'hF, 32'hFFFF_FFFC | i);
         chk(dma_request_pin_select, i);
         u_host.wr(8'h98, 4'hF, 32'hFFFF_1239 | (i << 1));
         chk(dma_transfer_wide, i == 1);
      end
      u_host.rd(8'h98, d);
      chk(d, 32'h0000_1237);
      chk({dma_window_base, dma_window_decode_enable}, {12'h123, 1'b1});
      io_addr = 32'h0000_123C;
      io_valid = 1'b1;
      @(posedge mclk) #1;
      chk(dma_window_hit, 32'h1);
      io_addr = 32'h0001_123C;
      @(posedge mclk) #1;
      chk(dma_window_hit, 32'h0);
      io_addr = 32'h0000_123C;
      u_host.wr(8'h98, 4'h1, 32'h0000_0030);
      chk({dma_window_base, dma_window_decode_enable}, {12'h123, 1'b0});
      chk(dma_window_hit, 32'h0);
   endtask
   // Reset held three cycles, then each scenario in turn
   initial begin
      repeat (3) @(posedge mclk);
      #1 rst = 1'b0;
      t_reset;
      t_diag;
      t_route;
      t_dma;
      close_out;
   end
endmodule
